// [ppio_pkg.sv]
// shared constants and carrier types for the programmable parallel io port
package ppio_pkg;

    // ------------------------------------------------------------
    // port widths and buffering
    // ------------------------------------------------------------
    localparam int PORT_W = 8;
    localparam int NUM_PORTS = 3;
    localparam int FIFO_DEPTH = 4;

    // ------------------------------------------------------------
    // group modes and host port select codes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_PLAIN = 2'h0;
    localparam logic [1:0] MODE_STROBED = 2'h1;
    localparam logic [1:0] MODE_BIDIR = 2'h2;
    localparam logic [1:0] SEL_A = 2'h0;
    localparam logic [1:0] SEL_B = 2'h1;
    localparam logic [1:0] SEL_C = 2'h2;

    // ------------------------------------------------------------
    // port c bit positions of the handshake lines
    // ------------------------------------------------------------
    localparam int CBIT_OUT_FULL_A = 7;
    localparam int CBIT_ACK_A = 6;
    localparam int CBIT_IN_FULL_A = 5;
    localparam int CBIT_STROBE_A = 4;
    localparam int CBIT_REQ_A = 3;
    localparam int CBIT_STROBE_ACK_B = 2;
    localparam int CBIT_FULL_B = 1;
    localparam int CBIT_REQ_B = 0;
    localparam int NIB_W = 4;

    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hFF;

    // ------------------------------------------------------------
    // configuration carrier; a direction bit of 1 means input
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] mode_a;
        logic mode_b;
        logic dir_a;
        logic dir_b;
        logic dir_c_hi;
        logic dir_c_lo;
        logic inte_a_in;
        logic inte_a_out;
        logic inte_b;
    } ppio_cfg_t;

    // one set of pin signals for an 8-bit port
    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] oe;
    } ppio_pin_t;

endpackage

// [ppio.sv]
// programmable 24-line parallel io port with handshaked transfers and input fifo

// ------------------------------------------------------------
// fifo
// ------------------------------------------------------------
module ppio_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    wire [AW-1:0] wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
    wire [AW-1:0] rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;

    assign in_ready = (count_r != (AW + 1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = mem[rd_ptr_r];

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_r] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_nxt;
            if (pop)
                rd_ptr_r <= rd_ptr_nxt;
            if (push && !pop)
                count_r <= count_r + 1'b1;
            else if (pop && !push)
                count_r <= count_r - 1'b1;
        end
    end
endmodule

// ------------------------------------------------------------
// top
// ------------------------------------------------------------
module ppio (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // configuration
    input wire ppio_pkg::ppio_cfg_t CFG,
    // host access, strobes from the parallel-port logic on CLK
    input wire logic HOST_WRITE_STROBE_N,
    input wire logic HOST_READ_STROBE_N,
    input wire logic [1:0] HOST_SEL,
    input wire logic [7:0] HOST_WDATA,
    output logic [7:0] HOST_RDATA,
    // port a pins
    input wire logic [7:0] PORT_A_LINES_IN,
    output logic [7:0] PORT_A_LINES_OUT,
    output logic [7:0] PORT_A_LINES_OE,
    // port b pins
    input wire logic [7:0] PORT_B_LINES_IN,
    output logic [7:0] PORT_B_LINES_OUT,
    output logic [7:0] PORT_B_LINES_OE,
    // port c pins
    input wire logic [7:0] PORT_C_LINES_IN,
    output logic [7:0] PORT_C_LINES_OUT,
    output logic [7:0] PORT_C_LINES_OE
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [23:0] pin_s1_r;
    logic [23:0] pin_s2_r;
    logic [1:0] hs_prev_r;
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            pin_s1_r <= '1;
            pin_s2_r <= '1;
        end
        else
        begin
            pin_s1_r <= {PORT_C_LINES_IN, PORT_B_LINES_IN, PORT_A_LINES_IN};
            pin_s2_r <= pin_s1_r;
        end
    end
    wire [7:0] a_in = pin_s2_r[7:0];
    wire [7:0] b_in = pin_s2_r[15:8];
    wire [7:0] c_in = pin_s2_r[23:16];

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    wire a_m1 = (CFG.mode_a == ppio_pkg::MODE_STROBED);
    wire a_m2 = (CFG.mode_a == ppio_pkg::MODE_BIDIR);
    wire a_hs_in = (a_m1 & CFG.dir_a) | a_m2;
    wire a_hs_out = (a_m1 & ~CFG.dir_a) | a_m2;
    wire b_hs_in = CFG.mode_b & CFG.dir_b;
    wire b_hs_out = CFG.mode_b & ~CFG.dir_b;

    // handshake inputs, all active low
    wire strobe_a_n = c_in[ppio_pkg::CBIT_STROBE_A];
    wire ack_a_n = c_in[ppio_pkg::CBIT_ACK_A];
    wire strobe_ack_b_n = c_in[ppio_pkg::CBIT_STROBE_ACK_B];
    wire a_side_n = a_hs_in ? strobe_a_n : ack_a_n;
    wire strobe_a_fall = a_hs_in & hs_prev_r[0] & ~strobe_a_n;
    wire ack_a_fall = a_hs_out & ~a_hs_in & hs_prev_r[0] & ~ack_a_n;
    wire b_fall = CFG.mode_b & hs_prev_r[1] & ~strobe_ack_b_n;
    // mode 2 tracks ack on its own edge history via the bit 6 copy
    logic ack2_prev_r;
    wire ack_a2_fall = a_m2 & ack2_prev_r & ~ack_a_n;

    // ------------------------------------------------------------
    // host strobes
    // ------------------------------------------------------------
    logic wr_prev_n_r;
    logic rd_prev_n_r;
    wire wr_go = wr_prev_n_r & ~HOST_WRITE_STROBE_N;
    wire rd_go = rd_prev_n_r & ~HOST_READ_STROBE_N;
    wire wr_a = wr_go & (HOST_SEL == ppio_pkg::SEL_A);
    wire wr_b = wr_go & (HOST_SEL == ppio_pkg::SEL_B);
    wire wr_c = wr_go & (HOST_SEL == ppio_pkg::SEL_C);
    wire rd_a = rd_go & (HOST_SEL == ppio_pkg::SEL_A);
    wire rd_b = rd_go & (HOST_SEL == ppio_pkg::SEL_B);

    // ------------------------------------------------------------
    // port a input fifo; full refuses further strobes until read
    // ------------------------------------------------------------
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    ppio_fifo #(
        .WIDTH(ppio_pkg::PORT_W),
        .DEPTH(ppio_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK),
        .rst(SYS_RST),
        .in_valid(strobe_a_fall),
        .in_ready(fifo_in_ready),
        .in_data(a_in),
        .out_valid(fifo_out_valid),
        .out_ready(rd_a & a_hs_in),
        .out_data(fifo_out_data)
    );
    wire ibuf_a = a_hs_in & fifo_out_valid;

    // ------------------------------------------------------------
    // latches and handshake flags
    // ------------------------------------------------------------
    logic [7:0] out_a_r;
    logic [7:0] out_b_r;
    logic [7:0] out_c_r;
    logic [7:0] in_b_r;
    logic ibuf_b_r;
    logic obuf_a_n_r;
    logic obuf_b_n_r;
    logic req_a_r;
    logic req_b_r;
    logic [7:0] rdata_r;

    // a write wins over a same-cycle ack, so new data is never lost
    wire obuf_a_n_nxt = (wr_a & a_hs_out) ? 1'b0 : (ack_a_fall | ack_a2_fall) ? 1'b1 : obuf_a_n_r;
    wire obuf_b_n_nxt = (wr_b & b_hs_out) ? 1'b0 : (b_fall & b_hs_out) ? 1'b1 : obuf_b_n_r;
    // a strobe wins over a same-cycle read
    wire ibuf_b_nxt = (b_fall & b_hs_in) ? 1'b1 : ((rd_b & b_hs_in) ? 1'b0 : ibuf_b_r);
    wire req_a_in = CFG.inte_a_in & ibuf_a & strobe_a_n;
    wire req_a_out = CFG.inte_a_out & a_hs_out & obuf_a_n_r & ack_a_n;
    wire req_b_nxt = CFG.inte_b & (b_hs_in ? (ibuf_b_r & strobe_ack_b_n)
                                           : (b_hs_out & obuf_b_n_r & strobe_ack_b_n));

    wire [7:0] rd_a_val = a_hs_in ? fifo_out_data : (CFG.dir_a ? a_in : out_a_r);
    wire [7:0] rd_b_val = b_hs_in ? in_b_r : (CFG.dir_b ? b_in : out_b_r);
    wire [7:0] rd_val = (HOST_SEL == ppio_pkg::SEL_A) ? rd_a_val :
                        (HOST_SEL == ppio_pkg::SEL_B) ? rd_b_val :
                        (HOST_SEL == ppio_pkg::SEL_C) ? c_in : ppio_pkg::BYTE_ZERO;

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            hs_prev_r <= '1;
            ack2_prev_r <= 1'b1;
            wr_prev_n_r <= 1'b1;
            rd_prev_n_r <= 1'b1;
            out_a_r <= ppio_pkg::BYTE_ZERO;
            out_b_r <= ppio_pkg::BYTE_ZERO;
            out_c_r <= ppio_pkg::BYTE_ZERO;
            in_b_r <= ppio_pkg::BYTE_ZERO;
            ibuf_b_r <= 1'b0;
            obuf_a_n_r <= 1'b1;
            obuf_b_n_r <= 1'b1;
            req_a_r <= 1'b0;
            req_b_r <= 1'b0;
            rdata_r <= ppio_pkg::BYTE_ZERO;
        end
        else
        begin
            hs_prev_r <= {strobe_ack_b_n, a_side_n};
            ack2_prev_r <= ack_a_n;
            wr_prev_n_r <= HOST_WRITE_STROBE_N;
            rd_prev_n_r <= HOST_READ_STROBE_N;
            if (wr_a)
                out_a_r <= HOST_WDATA;
            if (wr_b)
                out_b_r <= HOST_WDATA;
            if (wr_c)
                out_c_r <= HOST_WDATA;
            if (b_fall & b_hs_in)
                in_b_r <= b_in;
            ibuf_b_r <= ibuf_b_nxt;
            obuf_a_n_r <= obuf_a_n_nxt;
            obuf_b_n_r <= obuf_b_n_nxt;
            req_a_r <= req_a_in | req_a_out;
            req_b_r <= req_b_nxt;
            if (rd_go)
                rdata_r <= rd_val;
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    // mode 2 drives port a only while the partner holds ack low
    wire a_drive = a_m2 ? ~ack_a_n : ~CFG.dir_a;
    assign PORT_A_LINES_OUT = out_a_r;
    assign PORT_A_LINES_OE = a_drive ? ppio_pkg::BYTE_ONES : ppio_pkg::BYTE_ZERO;
    assign PORT_B_LINES_OUT = out_b_r;
    assign PORT_B_LINES_OE = CFG.dir_b ? ppio_pkg::BYTE_ZERO : ppio_pkg::BYTE_ONES;
    assign HOST_RDATA = rdata_r;

    // plain nibble drive first, handshake lines override per mode
    wire [7:0] c_plain_oe = {{ppio_pkg::NIB_W{~CFG.dir_c_hi}}, {ppio_pkg::NIB_W{~CFG.dir_c_lo}}};
    logic [7:0] c_out;
    logic [7:0] c_oe;
    always_comb
    begin
        c_out = out_c_r;
        c_oe = c_plain_oe;
        if (a_hs_in)
        begin
            c_out[ppio_pkg::CBIT_IN_FULL_A] = ibuf_a;
            c_oe[ppio_pkg::CBIT_IN_FULL_A] = 1'b1;
            c_oe[ppio_pkg::CBIT_STROBE_A] = 1'b0;
        end
        if (a_hs_out)
        begin
            c_out[ppio_pkg::CBIT_OUT_FULL_A] = obuf_a_n_r;
            c_oe[ppio_pkg::CBIT_OUT_FULL_A] = 1'b1;
            c_oe[ppio_pkg::CBIT_ACK_A] = 1'b0;
        end
        if (a_m1 | a_m2)
        begin
            c_out[ppio_pkg::CBIT_REQ_A] = req_a_r;
            c_oe[ppio_pkg::CBIT_REQ_A] = 1'b1;
        end
        if (CFG.mode_b & ~a_m2)
        begin
            c_out[ppio_pkg::CBIT_FULL_B] = b_hs_in ? ibuf_b_r : obuf_b_n_r;
            c_oe[ppio_pkg::CBIT_FULL_B] = 1'b1;
            c_oe[ppio_pkg::CBIT_STROBE_ACK_B] = 1'b0;
            c_out[ppio_pkg::CBIT_REQ_B] = req_b_r;
            c_oe[ppio_pkg::CBIT_REQ_B] = 1'b1;
        end
    end
    assign PORT_C_LINES_OUT = c_out;
    assign PORT_C_LINES_OE = c_oe;
endmodule

// [ppio_chk.sv]
// concurrent checks on the parallel io port pins and host strobes
module ppio_chk (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // configuration and host side
    input wire ppio_pkg::ppio_cfg_t CFG,
    input wire logic HOST_WRITE_STROBE_N,
    input wire logic HOST_READ_STROBE_N,
    input wire logic [1:0] HOST_SEL,
    input wire logic [7:0] HOST_RDATA,
    // pins
    input wire logic [7:0] PORT_A_LINES_OE,
    input wire logic [7:0] PORT_B_LINES_OE,
    input wire logic [7:0] PORT_C_LINES_IN,
    input wire logic [7:0] PORT_C_LINES_OUT,
    input wire logic [7:0] PORT_C_LINES_OE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    wire in_a = CFG.mode_a == ppio_pkg::MODE_STROBED && CFG.dir_a;
    wire out_a = CFG.mode_a == ppio_pkg::MODE_STROBED && !CFG.dir_a;
    wire b_hs = CFG.mode_b && CFG.mode_a != ppio_pkg::MODE_BIDIR;
    property p_dir;
        CFG.mode_a != ppio_pkg::MODE_BIDIR |->
            PORT_A_LINES_OE == {8{!CFG.dir_a}} && PORT_B_LINES_OE == {8{!CFG.dir_b}};
    endproperty
    a_dir: assert property (p_dir) else $error("port enables do not follow direction");
    property p_plain_c;
        CFG.mode_a == ppio_pkg::MODE_PLAIN && !CFG.mode_b |->
            PORT_C_LINES_OE == {{4{!CFG.dir_c_hi}}, {4{!CFG.dir_c_lo}}};
    endproperty
    a_plain_c: assert property (p_plain_c) else $error("port c nibble enables wrong");
    property p_in1;
        in_a && CFG.mode_b && CFG.dir_b |-> PORT_C_LINES_OE[5:0] == 6'h2B;
    endproperty
    a_in1: assert property (p_in1) else $error("strobed input line layout wrong");
    property p_out1;
        out_a && CFG.mode_b && !CFG.dir_b |->
            {PORT_C_LINES_OE[7:6], PORT_C_LINES_OE[3:0]} == 6'h2B;
    endproperty
    a_out1: assert property (p_out1) else $error("strobed output line layout wrong");
    property p_bidir;
        CFG.mode_a == ppio_pkg::MODE_BIDIR |-> PORT_C_LINES_OE[7:3] == 5'h15;
    endproperty
    a_bidir: assert property (p_bidir) else $error("two-way line layout wrong");
    property p_fill;
        out_a && $fell(HOST_WRITE_STROBE_N) && HOST_SEL == ppio_pkg::SEL_A |->
            ##[1:2] !PORT_C_LINES_OUT[7];
    endproperty
    a_fill: assert property (p_fill) else $error("write did not mark output full");
    property p_ack_clear;
        (out_a && !PORT_C_LINES_IN[6])[*3] |-> ##[0:3] PORT_C_LINES_OUT[7];
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("ack left output full");
    property p_req_off;
        b_hs && !CFG.inte_b |=> !PORT_C_LINES_OUT[0];
    endproperty
    a_req_off: assert property (p_req_off) else $error("request raised while masked");
    property p_no_port;
        HOST_SEL == 2'h3 && $fell(HOST_READ_STROBE_N) |=> HOST_RDATA == ppio_pkg::BYTE_ZERO;
    endproperty
    a_no_port: assert property (p_no_port) else $error("unused select read nonzero");
endmodule

bind ppio ppio_chk u_chk (.CLK, .SYS_RST, .CFG, .HOST_WRITE_STROBE_N, .HOST_READ_STROBE_N,
    .HOST_SEL, .HOST_RDATA, .PORT_A_LINES_OE, .PORT_B_LINES_OE, .PORT_C_LINES_IN,
    .PORT_C_LINES_OUT, .PORT_C_LINES_OE);

// [ppio_ext_dev.sv]
// external device that strobes bytes in and acknowledges bytes out
module ppio_ext_dev (
    // clock
    input wire logic clk,
    // lines driven toward the port pins
    output logic [7:0] a_lines,
    output logic [7:0] b_lines,
    output logic [7:0] c_lines
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        a_lines = 8'h00;
        b_lines = 8'h00;
        c_lines = 8'hFF;
    end
    // data turns to its inverse two cycles after the strobe is released, so a late capture reads wrong
    task automatic put_byte(input logic on_b, input logic [7:0] v, input int lag);
        repeat (lag + 1) @(posedge clk);
        #10;
        if (on_b)
            b_lines = v;
        else
            a_lines = v;
        c_lines[on_b ? 2 : 4] = 1'h0;
        repeat (3) @(posedge clk);
        #10;
        c_lines[on_b ? 2 : 4] = 1'h1;
        repeat (2) @(posedge clk);
        #10;
        if (on_b)
            b_lines = ~v;
        else
            a_lines = ~v;
        repeat (3) @(posedge clk);
        #10;
    endtask
    task automatic ack(input logic on_b, input int lag);
        repeat (lag + 1) @(posedge clk);
        #10;
        c_lines[on_b ? 2 : 6] = 1'h0;
        repeat (3) @(posedge clk);
        #10;
        c_lines[on_b ? 2 : 6] = 1'h1;
        repeat (4) @(posedge clk);
        #10;
    endtask
endmodule

// [ppio_tb_top.sv]
// self-checking bench for the parallel io port
module ppio_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0;
    logic rst = 1'h1;
    ppio_pkg::ppio_cfg_t cfg = 10'h028;
    logic wr_n = 1'h1;
    logic rd_n = 1'h1;
    logic [1:0] sel = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, a_out, a_oe, b_out, b_oe, c_out, c_oe, ext_a, ext_b, ext_c, d;
    wire [7:0] a_pin = (a_oe & a_out) | (~a_oe & ext_a);
    wire [7:0] b_pin = (b_oe & b_out) | (~b_oe & ext_b);
    wire [7:0] c_pin = (c_oe & c_out) | (~c_oe & ext_c);
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    ppio DUT (.CLK(clk), .SYS_RST(rst), .CFG(cfg), .HOST_WRITE_STROBE_N(wr_n),
        .HOST_READ_STROBE_N(rd_n), .HOST_SEL(sel), .HOST_WDATA(wdata), .HOST_RDATA(rdata),
        .PORT_A_LINES_IN(a_pin), .PORT_A_LINES_OUT(a_out), .PORT_A_LINES_OE(a_oe),
        .PORT_B_LINES_IN(b_pin), .PORT_B_LINES_OUT(b_out), .PORT_B_LINES_OE(b_oe),
        .PORT_C_LINES_IN(c_pin), .PORT_C_LINES_OUT(c_out), .PORT_C_LINES_OE(c_oe));
    ppio_ext_dev u_ext (.clk(clk), .a_lines(ext_a), .b_lines(ext_b), .c_lines(ext_c));
    task automatic finish_test();
        $display("bad_count %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want)
        begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            bad_count++;
            $display("Error at %0t: run too long", $time);
            finish_test();
        end
    end
    // configuration is static, so every change goes through a reset
    task automatic new_cfg(input logic [9:0] c);
        @(posedge clk);
        #10;
        rst = 1'h1;
        cfg = c;
        repeat (2) @(posedge clk);
        #10;
        rst = 1'h0;
    endtask
    task automatic wr(input logic [1:0] s, input logic [7:0] v);
        @(posedge clk);
        #10;
        sel = s;
        wdata = v;
        wr_n = 1'h0;
        @(posedge clk);
        #10;
        wr_n = 1'h1;
    endtask
    // leading wait lets pin changes cross the input synchronisers
    task automatic rd(input logic [1:0] s, output logic [7:0] v);
        repeat (3) @(posedge clk);
        #10;
        sel = s;
        rd_n = 1'h0;
        @(posedge clk);
        #10;
        rd_n = 1'h1;
        v = rdata;
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        #10;
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        #10;
        rst = 1'h0;
        u_ext.b_lines = 8'h3C;
        u_ext.c_lines = 8'h06;
        wr(ppio_pkg::SEL_A, 8'hA5);
        check(a_pin, 8'hA5);
        check(a_oe, ppio_pkg::BYTE_ONES);
        check(b_oe, ppio_pkg::BYTE_ZERO);
        rd(ppio_pkg::SEL_B, d);
        check(d, 8'h3C);
        wr(ppio_pkg::SEL_C, 8'h9F);
        check(c_oe, 8'hF0);
        rd(ppio_pkg::SEL_C, d);
        check(d, 8'h96);
        rd(2'h3, d);
        check(d, ppio_pkg::BYTE_ZERO);
        u_ext.c_lines = 8'hFF;
        new_cfg(10'h1E5);
        check(c_oe, 8'hEB);
        for (int i = 1; i < 6; i++)
            u_ext.put_byte(1'h0, 8'(8'h11 * i), 0);
        check(c_pin & 8'h2B, 8'h28);
        for (int i = 1; i < 5; i++)
        begin
            rd(ppio_pkg::SEL_A, d);
            check(d, 8'(8'h11 * i));
        end
        settle();
        check(c_pin & 8'h2B, 8'h00);
        u_ext.put_byte(1'h1, 8'hB7, 5);
        settle();
        check(c_pin & 8'h03, 8'h03);
        rd(ppio_pkg::SEL_B, d);
        check(d, 8'hB7);
        settle();
        check(c_pin & 8'h03, 8'h00);
        new_cfg(10'h182);
        check(c_oe, 8'hBB);
        wr(ppio_pkg::SEL_A, 8'h5A);
        settle();
        check(a_pin, 8'h5A);
        check(c_pin & 8'h88, 8'h00);
        u_ext.ack(1'h0, 0);
        check(c_pin & 8'h88, 8'h88);
        wr(ppio_pkg::SEL_B, 8'hC3);
        settle();
        check(b_pin, 8'hC3);
        check(c_pin & 8'h03, 8'h00);
        u_ext.ack(1'h1, 3);
        check(c_pin & 8'h03, 8'h02);
        new_cfg(10'h226);
        check(c_oe, 8'hAF);
        wr(ppio_pkg::SEL_A, 8'h69);
        settle();
        check(a_oe, ppio_pkg::BYTE_ZERO);
        fork
            u_ext.ack(1'h0, 0);
            begin
                repeat (4) @(posedge clk);
                #10;
                check(a_pin, 8'h69);
            end
        join
        u_ext.put_byte(1'h0, 8'h96, 0);
        check(c_pin & 8'hA0, 8'hA0);
        rd(ppio_pkg::SEL_A, d);
        check(d, 8'h96);
        finish_test();
    end
endmodule
